// File: core/dcc_ctrl.sv
/*
 dma channel control slice: structure select, priority,
 bus error flag, interrupt enable and pending bits.
 assumes a single clock, a plain register port and a
 transfer engine that pulses struct done and bus error.
*/
// What this block does
// RULE1: writing 1 to bit n of primary_select_clear puts channel n on primary.
// RULE2: in scatter-gather cycles, finishing the four primary transfers flips the select.
// RULE3: in ping-pong and memory scatter-gather, finishing alternate flips the select.
// RULE4: priority_high_set reads the priority bits, 1 sets high, resets to zero.
// RULE5: writing 1 to bit n of priority_default_clear returns n to default.
// RULE6: bit 0 of bus_error_flag_clear reads the flag, and a 1 written clears it.
// RULE7: a bus error in the clearing cycle keeps the flag set.
// RULE8: irq_enable holds error enable in bit 3 and done enables in 2:0, reset 0.
// RULE9: pending bits set on rising edges of bus error flag and channel done.
// RULE10: the interrupt is high while any pending bit has its enable set.
// RULE11: reading irq_pending leaves the pending bits alone.
// RULE12: writing irq_pending clears exactly the bits written as 1.
// RULE13: irq_pending has error in bit 3 and done in 2:0, resetting to zero.
// RULE14: the alternate select set register reads the select, 1 sets alternate.
// RULE15: a pending set in the same cycle as its clear wins.
`timescale 1ns/1ps
`include "dcc_defines.svh"
module dcc_ctrl (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [`DCC_AW-1:0] addr,
  input wire logic [`DCC_DW-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [`DCC_DW-1:0] rdata,
  input wire dcc_pkg::dcc_mode_e ch0_mode,
  input wire dcc_pkg::dcc_mode_e ch1_mode,
  input wire dcc_pkg::dcc_mode_e ch2_mode,
  input wire logic [`DCC_NCH-1:0] struct_done,
  input wire logic [`DCC_NCH-1:0] ch_done,
  input wire logic bus_err_resp,
  output logic [`DCC_NCH-1:0] alt_select,
  output logic [`DCC_NCH-1:0] priority_high,
  output logic bus_err_flag,
  output logic irq
);
  // ==========================================
  // address decode
  logic sel_alt_set;
  logic sel_pri_clr;
  logic sel_priority_high_set;
  logic sel_priority_default_clear;
  logic sel_err;
  logic sel_en;
  logic sel_pend;
  assign sel_alt_set = (addr == `DCC_OFS_ALT_SET);
  assign sel_pri_clr = (addr == `DCC_OFS_PRI_CLR);
  assign sel_priority_high_set = (addr == `DCC_OFS_PRIORITY_HIGH_SET);
  assign sel_priority_default_clear = (addr == `DCC_OFS_PRIORITY_DEFAULT_CLEAR);
  assign sel_err = (addr == `DCC_OFS_ERR_CLR);
  assign sel_en = (addr == `DCC_OFS_IRQ_EN);
  assign sel_pend = (addr == `DCC_OFS_IRQ_PEND);

  logic [`DCC_NCH-1:0] wch;
  assign wch = wdata[`DCC_NCH-1:0];

  // ==========================================
  // structure select
  // cycle type per channel, held steady by the engine
  dcc_pkg::dcc_mode_e mode [`DCC_NCH];
  assign mode[0] = ch0_mode;
  assign mode[1] = ch1_mode;
  assign mode[2] = ch2_mode;

  logic [`DCC_NCH-1:0] alt_reg;
  logic [`DCC_NCH-1:0] alt_next;
  logic [`DCC_NCH-1:0] flip;

  genvar g;
  generate
    for (g = 0; g < `DCC_NCH; g++) begin : g_ch
      logic prim_end;
      logic alt_end;
      // primary end: four sg transfers, or a ping-pong half
      assign prim_end = struct_done[g] && !alt_reg[g] &&
        (mode[g] == dcc_pkg::DCC_MEM_SG ||
         mode[g] == dcc_pkg::DCC_PER_SG ||
         mode[g] == dcc_pkg::DCC_PING_PONG); // RULE2
      assign alt_end = struct_done[g] && alt_reg[g] &&
        (mode[g] == dcc_pkg::DCC_PING_PONG ||
         mode[g] == dcc_pkg::DCC_MEM_SG); // RULE3
      assign flip[g] = prim_end || alt_end;
    end
  endgenerate

  // software writes win over a hardware flip
  always_comb begin
    alt_next = alt_reg ^ flip;
    if (wr && sel_alt_set) begin
      alt_next = alt_reg | wch; // RULE14
    end else if (wr && sel_pri_clr) begin
      alt_next = alt_reg & ~wch; // RULE1
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      alt_reg <= `DCC_RST_CH;
    end else begin
      alt_reg <= alt_next;
    end
  end
  assign alt_select = alt_reg;

  // ==========================================
  // priority
  // set and clear sit at two addresses, so never collide
  logic [`DCC_NCH-1:0] prio_reg;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prio_reg <= `DCC_RST_CH; // RULE4
    end else if (wr && sel_priority_high_set) begin
      prio_reg <= prio_reg | wch; // RULE4
    end else if (wr && sel_priority_default_clear) begin
      prio_reg <= prio_reg & ~wch; // RULE5
    end
  end
  assign priority_high = prio_reg;

  // ==========================================
  // bus error flag
  logic err_reg;
  logic err_clr;
  // a new error outranks a clear in the same cycle
  assign err_clr = wr && sel_err && wdata[0];
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      err_reg <= `DCC_RST_ERR;
    end else begin
      err_reg <= bus_err_resp || (err_reg && !err_clr); // RULE7
    end
  end
  assign bus_err_flag = err_reg;

  // ==========================================
  // interrupt enable and pending
  logic [`DCC_IRQ_W-1:0] en_reg;
  logic [`DCC_IRQ_W-1:0] pend_reg;
  logic [`DCC_IRQ_W-1:0] src;
  logic [`DCC_IRQ_W-1:0] src_q;
  logic [`DCC_IRQ_W-1:0] rise;
  logic [`DCC_IRQ_W-1:0] pend_clr;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      en_reg <= `DCC_RST_IRQ; // RULE8
    end else if (wr && sel_en) begin
      en_reg <= wdata[`DCC_IRQ_W-1:0]; // RULE8
    end
  end

  // every source idles low, so reset makes no false edge
  assign src = {err_reg, ch_done};
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      src_q <= `DCC_RST_IRQ;
    end else begin
      src_q <= src;
    end
  end
  assign rise = src & ~src_q; // RULE9

  // a rise outranks a clear in the same cycle
  assign pend_clr = (wr && sel_pend) ?
    wdata[`DCC_IRQ_W-1:0] : `DCC_RST_IRQ;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pend_reg <= `DCC_RST_IRQ; // RULE13
    end else begin
      pend_reg <= rise | (pend_reg & ~pend_clr); // RULE12 RULE15
    end
  end

  assign irq = |(pend_reg & en_reg); // RULE10

  // ==========================================
  // read port
  // read data stand one cycle, zero otherwise
  logic [`DCC_DW-1:0] rdata_reg;
  logic [`DCC_DW-1:0] rd_val;
  always_comb begin
    rd_val = `DCC_RST_DATA;
    if (sel_alt_set) begin
      rd_val[`DCC_NCH-1:0] = alt_reg; // RULE14
    end else if (sel_priority_high_set) begin
      rd_val[`DCC_NCH-1:0] = prio_reg; // RULE4
    end else if (sel_err) begin
      rd_val[0] = err_reg; // RULE6
    end else if (sel_en) begin
      rd_val[`DCC_IRQ_W-1:0] = en_reg; // RULE8
    end else if (sel_pend) begin
      rd_val[`DCC_IRQ_W-1:0] = pend_reg; // RULE11 RULE13
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_reg <= `DCC_RST_DATA;
    end else if (rd) begin
      rdata_reg <= rd_val;
    end else begin
      rdata_reg <= `DCC_RST_DATA;
    end
  end
  assign rdata = rdata_reg;

  // ==========================================
  // checks
  property p_pri_clr;
    @(posedge clk) disable iff (!rst_n)
    (wr && sel_pri_clr && wdata[0]) |=> !alt_select[0];
  endproperty
  a_pri_clr: assert property (p_pri_clr) // RULE1
    else $error("primary clear did not select primary");

  property p_pri_keep;
    @(posedge clk) disable iff (!rst_n)
    (wr && sel_pri_clr && !wdata[0] && !flip[0])
      |=> $stable(alt_select[0]);
  endproperty
  a_pri_keep: assert property (p_pri_keep) // RULE1
    else $error("zero in primary clear changed select");

  property p_sg_flip;
    @(posedge clk) disable iff (!rst_n)
    (struct_done[1] && !alt_select[1] &&
     (ch1_mode == dcc_pkg::DCC_PER_SG) &&
     !(wr && (sel_alt_set || sel_pri_clr)))
      |=> alt_select[1];
  endproperty
  a_sg_flip: assert property (p_sg_flip) // RULE2
    else $error("scatter-gather primary end did not flip");

  property p_alt_flip;
    @(posedge clk) disable iff (!rst_n)
    (struct_done[0] && alt_select[0] &&
     (ch0_mode == dcc_pkg::DCC_PING_PONG) &&
     !(wr && (sel_alt_set || sel_pri_clr)))
      |=> !alt_select[0];
  endproperty
  a_alt_flip: assert property (p_alt_flip) // RULE3
    else $error("alternate end did not flip back");

  property p_basic_hold;
    @(posedge clk) disable iff (!rst_n)
    ((ch1_mode == dcc_pkg::DCC_BASIC) && !wr)
      |=> $stable(alt_select[1]);
  endproperty
  a_basic_hold: assert property (p_basic_hold) // RULE2
    else $error("basic cycle changed select");

  property p_priority_high_set;
    @(posedge clk) disable iff (!rst_n)
    (rd && sel_priority_high_set)
      |=> (rdata == {29'h0, $past(priority_high, 1)});
  endproperty
  a_priority_high_set: assert property (p_priority_high_set) // RULE4
    else $error("priority read back wrong");

  property p_prio_up;
    @(posedge clk) disable iff (!rst_n)
    (wr && sel_priority_high_set)
      |=> ((priority_high & $past(wch)) == $past(wch));
  endproperty
  a_prio_up: assert property (p_prio_up) // RULE4
    else $error("priority set bit not raised");

  property p_priority_default_clear;
    @(posedge clk) disable iff (!rst_n)
    (wr && sel_priority_default_clear) |=> ((priority_high & $past(wch)) == 3'h0)
      && ((priority_high & ~$past(wch)) ==
          ($past(priority_high) & ~$past(wch)));
  endproperty
  a_priority_default_clear: assert property (p_priority_default_clear) // RULE5
    else $error("priority clear wrong");

  property p_err_read;
    @(posedge clk) disable iff (!rst_n)
    (rd && sel_err) |=> (rdata == {31'h0, $past(bus_err_flag)});
  endproperty
  a_err_read: assert property (p_err_read) // RULE6
    else $error("bus error read wrong");

  property p_err_clr;
    @(posedge clk) disable iff (!rst_n)
    (err_clr && !bus_err_resp) |=> !bus_err_flag;
  endproperty
  a_err_clr: assert property (p_err_clr) // RULE6
    else $error("bus error flag not cleared");

  property p_err_win;
    @(posedge clk) disable iff (!rst_n)
    (bus_err_resp && err_clr) |=> bus_err_flag ##1 bus_err_flag
      || $past(err_clr);
  endproperty
  a_err_win: assert property (p_err_win) // RULE7
    else $error("clear beat a new bus error");

  property p_en_rd;
    @(posedge clk) disable iff (!rst_n)
    (wr && sel_en) ##1 !wr ##1 (rd && sel_en)
      |=> (rdata[`DCC_IRQ_W-1:0] == $past(wdata[3:0], 3));
  endproperty
  a_en_rd: assert property (p_en_rd) // RULE8
    else $error("enable register read back wrong");

  property p_done_rise;
    @(posedge clk) disable iff (!rst_n)
    $rose(ch_done[1]) |=> pend_reg[1];
  endproperty
  a_done_rise: assert property (p_done_rise) // RULE9
    else $error("done rise did not set pending");

  property p_err_rise;
    @(posedge clk) disable iff (!rst_n)
    $rose(bus_err_flag) |=> pend_reg[`DCC_ERR_BIT];
  endproperty
  a_err_rise: assert property (p_err_rise) // RULE9
    else $error("error rise did not set pending");

  property p_irq;
    @(posedge clk) disable iff (!rst_n)
    irq == ((pend_reg & en_reg) != 4'h0);
  endproperty
  a_irq: assert property (p_irq) // RULE10
    else $error("interrupt does not match pending and enable");

  property p_pend_rd;
    @(posedge clk) disable iff (!rst_n)
    (rd && sel_pend) |=> (pend_reg & ~$past(rise)) ==
      ($past(pend_reg) & ~$past(rise))
      ##0 (rdata[3:0] == $past(pend_reg));
  endproperty
  a_pend_rd: assert property (p_pend_rd) // RULE11
    else $error("pending read altered bits");

  property p_pend_w1c;
    @(posedge clk) disable iff (!rst_n)
    (wr && sel_pend && rise == 4'h0) |=>
      pend_reg == ($past(pend_reg) & ~$past(wdata[3:0]));
  endproperty
  a_pend_w1c: assert property (p_pend_w1c) // RULE12
    else $error("pending write did not clear exact bits");

  property p_set_wins;
    @(posedge clk) disable iff (!rst_n)
    (wr && sel_pend && wdata[0] && rise[0]) |=> pend_reg[0];
  endproperty
  a_set_wins: assert property (p_set_wins) // RULE15
    else $error("clear beat a pending set");

  property p_alt_set;
    @(posedge clk) disable iff (!rst_n)
    (wr && sel_alt_set && wdata[2]) |=> alt_select[2];
  endproperty
  a_alt_set: assert property (p_alt_set) // RULE14
    else $error("alternate set did not select alternate");

  property p_pend_rst;
    @(posedge clk)
    !rst_n |=> (pend_reg == 4'h0) && (en_reg == 4'h0) && !irq;
  endproperty
  a_pend_rst: assert property (p_pend_rst) // RULE13
    else $error("pending or enable not zero after reset");

endmodule

// File: core/dcc_defines.svh
/*
 register offsets, field positions, reset values of the
 dma channel control and interrupt slice; definitions only
*/
`ifndef DCC_DEFINES_SVH
`define DCC_DEFINES_SVH
// ==========================================
// widths
`define DCC_NCH 3
`define DCC_AW 32
`define DCC_DW 32
// ==========================================
// offsets
`define DCC_OFS_ALT_SET 32'h40800030
`define DCC_OFS_PRI_CLR 32'h40800034
`define DCC_OFS_PRIORITY_HIGH_SET 32'h40800038
`define DCC_OFS_PRIORITY_DEFAULT_CLEAR 32'h4080003C
`define DCC_OFS_ERR_CLR 32'h4080004C
`define DCC_OFS_IRQ_EN 32'h40800050
`define DCC_OFS_IRQ_PEND 32'h40800054
// ==========================================
// fields
`define DCC_ERR_BIT 3
`define DCC_IRQ_W 4
// ==========================================
// reset values
`define DCC_RST_CH 3'h0
`define DCC_RST_IRQ 4'h0
`define DCC_RST_ERR 1'h0
`define DCC_RST_DATA 32'h00000000
`endif

// File: core/dcc_pkg.sv
/*
 types of the dma channel control and interrupt slice
 assumes nothing beyond the defines header
*/
package dcc_pkg;
  // ==========================================
  // dma cycle type of a channel, one-hot
  typedef enum logic [3:0] {
    DCC_BASIC = 4'h1,
    DCC_PING_PONG = 4'h2,
    DCC_MEM_SG = 4'h4,
    DCC_PER_SG = 4'h8
  } dcc_mode_e;
  typedef logic [2:0] dcc_ch_t;
endpackage

// File: bench/dcc_host.sv
/*
 processor side bus master model for the channel control slice
 assumes the plain register port: one-cycle strobes, read data
 in the cycle after the read strobe, no wait states
*/
`timescale 1ns/1ps
module dcc_host (
  input wire logic clk,
  output logic [31:0] addr,
  output logic [31:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [31:0] rdata
);
  // ==========================================
  // idle bus
  initial begin
    addr = 32'h00000000;
    wdata = 32'h00000000;
    wr = 1'b0;
    rd = 1'b0;
  end
  // ==========================================
  // one-cycle write
  task automatic wr_reg(input logic [31:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    wdata <= ~v;
  endtask
  // ==========================================
  // one-cycle read, data taken in the following cycle
  task automatic rd_reg(input logic [31:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask
endmodule

// File: bench/dcc_ctrl_tb.sv
/*
 self-checking testbench of the channel control slice
 assumes the host model and the design with its defines header
*/
`timescale 1ns/1ps
`include "dcc_defines.svh"
module dcc_ctrl_tb;
  logic clk, rst_n, wr, rd, bus_err_resp, bus_err_flag, irq;
  logic [31:0] addr, wdata, rdata, d;
  logic [2:0] struct_done, ch_done, alt_select, priority_high;
  dcc_pkg::dcc_mode_e m0, m1, m2;
  int fail_count, n_tests;
  dcc_host host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata));
  dcc_ctrl dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .ch0_mode(m0), .ch1_mode(m1),
    .ch2_mode(m2), .struct_done(struct_done), .ch_done(ch_done),
    .bus_err_resp(bus_err_resp), .alt_select(alt_select),
    .priority_high(priority_high), .bus_err_flag(bus_err_flag),
    .irq(irq));
  // ==========================================
  // clock, watchdog, verdict
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #200000;
    fail_count++;
    close_out();
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ==========================================
  // compare helpers
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rchk(input logic [31:0] a, input logic [31:0] e);
    host.rd_reg(a, d);
    chk(d, e);
  endtask
  task automatic pulse_sd(input logic [2:0] v);
    @(posedge clk);
    struct_done <= v;
    @(posedge clk);
    struct_done <= 3'h0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  // ==========================================
  // tests
  initial begin
    rst_n = 1'b0;
    bus_err_resp = 1'b0;
    struct_done = 3'h0;
    ch_done = 3'h0;
    m0 = dcc_pkg::DCC_PING_PONG;
    m1 = dcc_pkg::DCC_PER_SG;
    m2 = dcc_pkg::DCC_MEM_SG;
    fail_count = 0;
    n_tests = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rchk(`DCC_OFS_ALT_SET, 32'h0);
    rchk(`DCC_OFS_PRIORITY_HIGH_SET, 32'h0);
    rchk(`DCC_OFS_ERR_CLR, 32'h0);
    rchk(`DCC_OFS_IRQ_EN, 32'h0);
    rchk(`DCC_OFS_IRQ_PEND, 32'h0);
    // priority set and clear
    host.wr_reg(`DCC_OFS_PRIORITY_HIGH_SET, 32'h5);
    host.wr_reg(`DCC_OFS_PRIORITY_HIGH_SET, 32'h0);
    rchk(`DCC_OFS_PRIORITY_HIGH_SET, 32'h5);
    chk({29'h0, priority_high}, 32'h5);
    host.wr_reg(`DCC_OFS_PRIORITY_DEFAULT_CLEAR, 32'h1);
    rchk(`DCC_OFS_PRIORITY_HIGH_SET, 32'h4);
    // structure select by software and by completions
    host.wr_reg(`DCC_OFS_ALT_SET, 32'h7);
    host.wr_reg(`DCC_OFS_PRI_CLR, 32'h2);
    rchk(`DCC_OFS_ALT_SET, 32'h5);
    host.wr_reg(`DCC_OFS_PRI_CLR, 32'h7);
    #1;
    chk({29'h0, alt_select}, 32'h0);
    pulse_sd(3'h7);
    chk({29'h0, alt_select}, 32'h7);
    pulse_sd(3'h7);
    chk({29'h0, alt_select}, 32'h2);
    // a basic cycle never moves the select
    @(posedge clk);
    m1 <= dcc_pkg::DCC_BASIC;
    pulse_sd(3'h2);
    chk({29'h0, alt_select}, 32'h2);
    @(posedge clk);
    m1 <= dcc_pkg::DCC_PER_SG;
    rchk(32'h40800040, 32'h0);
    // bus error flag
    @(posedge clk);
    bus_err_resp <= 1'b1;
    @(posedge clk);
    bus_err_resp <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk({31'h0, bus_err_flag}, 32'h1);
    rchk(`DCC_OFS_ERR_CLR, 32'h1);
    rchk(`DCC_OFS_IRQ_PEND, 32'h8);
    fork
      host.wr_reg(`DCC_OFS_ERR_CLR, 32'h1);
      begin
        @(posedge clk);
        bus_err_resp <= 1'b1;
        @(posedge clk);
        bus_err_resp <= 1'b0;
      end
    join
    #1;
    chk({31'h0, bus_err_flag}, 32'h1);
    host.wr_reg(`DCC_OFS_ERR_CLR, 32'h1);
    #1;
    chk({31'h0, bus_err_flag}, 32'h0);
    // completion pending, enables, clearing
    @(posedge clk);
    ch_done <= 3'h2;
    repeat (3) @(posedge clk);
    rchk(`DCC_OFS_IRQ_PEND, 32'hA);
    chk({31'h0, irq}, 32'h0);
    host.wr_reg(`DCC_OFS_IRQ_EN, 32'h2);
    rchk(`DCC_OFS_IRQ_EN, 32'h2);
    chk({31'h0, irq}, 32'h1);
    host.wr_reg(`DCC_OFS_IRQ_EN, 32'h8);
    rchk(`DCC_OFS_IRQ_PEND, 32'hA);
    rchk(`DCC_OFS_IRQ_PEND, 32'hA);
    host.wr_reg(`DCC_OFS_IRQ_PEND, 32'h2);
    rchk(`DCC_OFS_IRQ_PEND, 32'h8);
    chk({31'h0, irq}, 32'h1);
    host.wr_reg(`DCC_OFS_IRQ_PEND, 32'h8);
    #1;
    chk({31'h0, irq}, 32'h0);
    rchk(`DCC_OFS_IRQ_PEND, 32'h0);
    // a done rise and its clear in one cycle: the rise wins
    fork
      host.wr_reg(`DCC_OFS_IRQ_PEND, 32'h1);
      begin
        @(posedge clk);
        ch_done <= 3'h1;
      end
    join
    rchk(`DCC_OFS_IRQ_PEND, 32'h1);
    // reset in mid-run returns every register to zero
    host.wr_reg(`DCC_OFS_PRIORITY_HIGH_SET, 32'h3);
    host.wr_reg(`DCC_OFS_IRQ_EN, 32'hF);
    #1;
    chk({31'h0, irq}, 32'h1);
    @(posedge clk);
    ch_done <= 3'h0;
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk({29'h0, priority_high}, 32'h0);
    chk({29'h0, alt_select}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    rchk(`DCC_OFS_IRQ_EN, 32'h0);
    rchk(`DCC_OFS_IRQ_PEND, 32'h0);
    close_out();
  end
endmodule
